// ### src/reset_source_pkg.sv
package reset_source_pkg;

  // Register byte offsets
  localparam logic [3:0] ORIGIN_OFS = 4'h0;
  localparam logic [3:0] SUPPLY_OFS = 4'h4;
  localparam logic [3:0] STROBE_OFS = 4'h8;

  // Reset origin register bit positions
  localparam int PIN_BIT = 0;
  localparam int POWER_BIT = 1;
  localparam int CLKLOSS_BIT = 2;
  localparam int WDOG_BIT = 3;
  localparam int SOFT_BIT = 4;
  localparam int CMP_BIT = 5;
  localparam int FLASH_BIT = 6;
  localparam int RTC_BIT = 7;

  // Supply monitor register bit positions: enable control and status
  localparam int SUPPLY_EN_BIT = 7;
  localparam int SUPPLY_OK_BIT = 5;

  // Strobe register: watchdog service
  localparam int WDOG_KICK_BIT = 0;

  // Values after reset
  localparam logic [7:0] PORT_LATCH_RST = 8'hFF;
  localparam logic [15:0] PC_RST = 16'h0000;

  // Timing
  localparam int CLK_MHZ = 125;
  localparam int POR_DELAY_US = 300;
  localparam int POR_DELAY_CYC = POR_DELAY_US * CLK_MHZ;
  localparam int WDOG_DIV = 12;
  localparam int CLKLOSS_WINDOW_CYC = 16;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10
  } seq_state_t;

endpackage

// ### src/reset_source_controller.sv
`timescale 1ns/1ps

module reset_source_controller #(
  parameter int POR_CYC = reset_source_pkg::POR_DELAY_CYC,
  parameter int WDOG_LIMIT = 4096
) (
  // Clock and power-on reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Reset pin, open drain
  input wire logic reset_pin_n_i,
  output logic reset_pin_n_o,
  output logic reset_pin_n_oe_o,
  // Analog and peripheral sources
  input wire logic supply_ok_i,
  input wire logic system_clock_i,
  input wire logic cmp_below_i,
  input wire logic rtc_alarm_i,
  input wire logic rtc_osc_fail_i,
  input wire logic flash_illegal_i,
  input wire logic flash_wr_req_i,
  // Core side
  output logic core_reset_o,
  output logic flash_wr_allow_o,
  output logic [7:0] port_latch_o,
  output logic port_pullup_o,
  output logic [15:0] pc_reset_o,
  output logic osc_internal_o,
  output logic wdog_enable_o
);

  // Asynchronous pins and analog levels pass two flops
  logic [1:0] pin_s_r, sup_s_r, clk_s_r, cmp_s_r, alm_s_r, osc_s_r;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s_r <= 2'h3;
      sup_s_r <= 2'h0;
      clk_s_r <= 2'h0;
      cmp_s_r <= 2'h0;
      alm_s_r <= 2'h0;
      osc_s_r <= 2'h0;
    end else begin
      pin_s_r <= {pin_s_r[0], reset_pin_n_i};
      sup_s_r <= {sup_s_r[0], supply_ok_i};
      clk_s_r <= {clk_s_r[0], system_clock_i};
      cmp_s_r <= {cmp_s_r[0], cmp_below_i};
      alm_s_r <= {alm_s_r[0], rtc_alarm_i};
      osc_s_r <= {osc_s_r[0], rtc_osc_fail_i};
    end
  end
  logic pin_low, sup_ok, clk_lvl, cmp_low, rtc_evt;
  assign pin_low = ~pin_s_r[1];
  assign sup_ok = sup_s_r[1];
  assign clk_lvl = clk_s_r[1];
  assign cmp_low = cmp_s_r[1];
  assign rtc_evt = alm_s_r[1] | osc_s_r[1];

  // Enables kept across device resets; only rst_i (power-on) returns them to their reset values
  logic sup_en_r, sup_sel_r, clk_en_r, cmp_sel_r, rtc_sel_r;
  reset_source_pkg::seq_state_t state_r;
  logic in_reset;
  assign in_reset = (state_r != reset_source_pkg::ST_RUN);

  // AXI write channel
  logic aw_hold_r, w_hold_r;
  logic [3:0] aw_addr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;
  assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_r & ~s_axi_bvalid;
  assign wr_fire = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 4'h0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= reset_source_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r == reset_source_pkg::ORIGIN_OFS || aw_addr_r == reset_source_pkg::SUPPLY_OFS ||
                        aw_addr_r == reset_source_pkg::STROBE_OFS) ? reset_source_pkg::RESP_OKAY
                                                                     : reset_source_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_origin, wr_supply, wr_kick;
  assign wr_origin = wr_fire && aw_addr_r == reset_source_pkg::ORIGIN_OFS && wstrb_r[0];
  assign wr_supply = wr_fire && aw_addr_r == reset_source_pkg::SUPPLY_OFS && wstrb_r[0];
  assign wr_kick = wr_fire && aw_addr_r == reset_source_pkg::STROBE_OFS && wstrb_r[0]
                   && wdata_r[reset_source_pkg::WDOG_KICK_BIT];

  // Writes set source enables, not flags
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sup_en_r <= 1'b1;
      sup_sel_r <= 1'b1;
      clk_en_r <= 1'b0;
      cmp_sel_r <= 1'b0;
      rtc_sel_r <= 1'b0;
    end else begin
      if (wr_supply) begin
        sup_en_r <= wdata_r[reset_source_pkg::SUPPLY_EN_BIT];
      end
      if (wr_origin) begin
        sup_sel_r <= wdata_r[reset_source_pkg::POWER_BIT];
        clk_en_r <= wdata_r[reset_source_pkg::CLKLOSS_BIT];
        cmp_sel_r <= wdata_r[reset_source_pkg::CMP_BIT];
        rtc_sel_r <= wdata_r[reset_source_pkg::RTC_BIT];
      end
    end
  end

  // Clock loss detector: stuck level longer than the window
  logic [7:0] clk_cnt_r;
  logic clk_prev_r;
  logic clk_lost;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_prev_r <= 1'b0;
      clk_cnt_r <= 8'h00;
    end else begin
      clk_prev_r <= clk_lvl;
      if (clk_lvl != clk_prev_r || !clk_en_r) begin
        clk_cnt_r <= 8'h00;
      end else if (clk_cnt_r != 8'(reset_source_pkg::CLKLOSS_WINDOW_CYC)) begin
        clk_cnt_r <= clk_cnt_r + 8'h01;
      end
    end
  end
  assign clk_lost = clk_en_r && clk_cnt_r == 8'(reset_source_pkg::CLKLOSS_WINDOW_CYC);

  // Watchdog on system clock divided by twelve
  logic [3:0] div_r;
  logic wd_tick;
  logic [15:0] wd_cnt_r;
  logic wd_fire;
  assign wd_tick = div_r == 4'(reset_source_pkg::WDOG_DIV - 1);
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_r <= 4'h0;
      wd_cnt_r <= 16'h0000;
    end else begin
      div_r <= wd_tick ? 4'h0 : div_r + 4'h1;
      if (in_reset || wr_kick) begin
        wd_cnt_r <= 16'h0000;
      end else if (wd_tick) begin
        wd_cnt_r <= wd_cnt_r + 16'h0001;
      end
    end
  end
  assign wd_fire = !in_reset && wd_cnt_r >= 16'(WDOG_LIMIT);
  assign wdog_enable_o = !in_reset;

  // Own drive reads back low through the pin; mask it until resynchronised
  // Limitation: an outside pull during own drive goes unseen
  logic [1:0] own_drive_r;
  logic pin_req;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      own_drive_r <= 2'h3;
    end else begin
      own_drive_r <= {own_drive_r[0], reset_pin_n_oe_o};
    end
  end
  assign pin_req = pin_low && !reset_pin_n_oe_o && own_drive_r == 2'h0;

  // Source requests
  logic sup_req, soft_req, cmp_req, rtc_req, any_req;
  assign sup_req = sup_en_r && sup_sel_r && !sup_ok;
  assign soft_req = wr_origin && wdata_r[reset_source_pkg::SOFT_BIT];
  assign cmp_req = cmp_sel_r && cmp_low;
  assign rtc_req = rtc_sel_r && rtc_evt;
  assign any_req = sup_req || pin_req || clk_lost || cmp_req || wd_fire || flash_illegal_i
                   || soft_req || rtc_req;

  // Reset sequencer; power-on delay runs only after rst_i
  logic [31:0] por_cnt_r;
  logic por_pending_r;
  logic drive_pin_r;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= reset_source_pkg::ST_HOLD;
      por_cnt_r <= 32'h0000_0000;
      por_pending_r <= 1'b1;
      drive_pin_r <= 1'b1;
    end else begin
      case (state_r)
        reset_source_pkg::ST_HOLD: begin
          if (!any_req && (!por_pending_r || sup_ok)) begin
            state_r <= por_pending_r ? reset_source_pkg::ST_WAIT : reset_source_pkg::ST_RUN;
            por_cnt_r <= 32'h0000_0000;
          end
        end
        reset_source_pkg::ST_WAIT: begin
          if (!sup_ok || any_req) begin
            state_r <= reset_source_pkg::ST_HOLD;
          end else if (por_cnt_r >= 32'(POR_CYC - 1)) begin
            state_r <= reset_source_pkg::ST_RUN;
            por_pending_r <= 1'b0;
          end else begin
            por_cnt_r <= por_cnt_r + 32'h0000_0001;
          end
        end
        reset_source_pkg::ST_RUN: begin
          if (any_req) begin
            state_r <= reset_source_pkg::ST_HOLD;
          end
        end
        default: begin
          state_r <= reset_source_pkg::ST_HOLD;
        end
      endcase
      if (state_r == reset_source_pkg::ST_RUN && any_req) begin
        drive_pin_r <= sup_req;
      end else if (state_r != reset_source_pkg::ST_HOLD || (!any_req && (!por_pending_r || sup_ok))) begin
        drive_pin_r <= por_pending_r && state_r != reset_source_pkg::ST_RUN ? drive_pin_r : 1'b0;
      end
    end
  end
  // Pin is driven only while held in reset
  assign reset_pin_n_o = 1'b0;
  assign reset_pin_n_oe_o = drive_pin_r && in_reset;
  assign core_reset_o = in_reset;
  assign port_latch_o = reset_source_pkg::PORT_LATCH_RST;
  assign port_pullup_o = 1'b1;
  assign pc_reset_o = reset_source_pkg::PC_RST;
  assign osc_internal_o = in_reset;

  // Flash writes refused while supply monitor is off
  assign flash_wr_allow_o = flash_wr_req_i && sup_en_r && !in_reset;

  // Cause flags latched on entry to reset; every source active in that cycle sets its own flag
  logic [7:0] flags_r;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_r <= 8'h02;
    end else if (state_r == reset_source_pkg::ST_RUN && any_req) begin
      flags_r <= 8'h00;
      flags_r[reset_source_pkg::POWER_BIT] <= sup_req;
      flags_r[reset_source_pkg::PIN_BIT] <= pin_req;
      flags_r[reset_source_pkg::CLKLOSS_BIT] <= clk_lost;
      flags_r[reset_source_pkg::WDOG_BIT] <= wd_fire;
      flags_r[reset_source_pkg::SOFT_BIT] <= soft_req;
      flags_r[reset_source_pkg::CMP_BIT] <= cmp_req;
      flags_r[reset_source_pkg::FLASH_BIT] <= flash_illegal_i;
      flags_r[reset_source_pkg::RTC_BIT] <= rtc_req;
    end
  end

  // AXI read channel
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      reset_source_pkg::ORIGIN_OFS: rd_val = {24'h000000, flags_r};
      reset_source_pkg::SUPPLY_OFS: begin
        rd_val[reset_source_pkg::SUPPLY_EN_BIT] = sup_en_r;
        rd_val[reset_source_pkg::SUPPLY_OK_BIT] = sup_ok;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= reset_source_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= (s_axi_araddr == reset_source_pkg::ORIGIN_OFS || s_axi_araddr == reset_source_pkg::SUPPLY_OFS
                      || s_axi_araddr == reset_source_pkg::STROBE_OFS) ? reset_source_pkg::RESP_OKAY
                                                                         : reset_source_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  AST_SOFT_RESET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state_r == reset_source_pkg::ST_RUN && soft_req) |=> (in_reset && flags_r[reset_source_pkg::SOFT_BIT]))
    else $error("soft reset not taken");
  AST_PIN_QUIET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state_r == reset_source_pkg::ST_RUN && any_req && !sup_req) |=> !reset_pin_n_oe_o)
    else $error("pin driven on quiet reset");
  AST_SUPPLY_DRIVE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state_r == reset_source_pkg::ST_RUN && sup_req) |=> (reset_pin_n_oe_o && core_reset_o))
    else $error("supply drop not driving pin");
  AST_FLASH_BLOCK: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !sup_en_r |-> !flash_wr_allow_o)
    else $error("flash write let through");
  AST_WDOG_FLAG: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state_r == reset_source_pkg::ST_RUN && wd_fire) |=> flags_r[reset_source_pkg::WDOG_BIT])
    else $error("watchdog flag missing");
  AST_POWER_CLEAR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state_r == reset_source_pkg::ST_RUN && any_req && !sup_req) |=> !flags_r[reset_source_pkg::POWER_BIT])
    else $error("power flag not cleared");
  AST_SUPPLY_NO_DELAY: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state_r == reset_source_pkg::ST_HOLD && !por_pending_r && !any_req) |=> state_r == reset_source_pkg::ST_RUN)
    else $error("supply release delayed");
  AST_HOLD_CORE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state_r == reset_source_pkg::ST_RUN && $rose(pin_req)) |=> core_reset_o)
    else $error("pin reset not held");
  AST_POR_DRIVE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (in_reset && por_pending_r) |-> reset_pin_n_oe_o)
    else $error("pin not driven during power-on hold");

endmodule

// ### testbench/analog_partner.sv
`timescale 1ns/1ps

module analog_partner (
  // Clock
  input wire logic sys_clk_i,
  // Bench commands
  input wire logic ext_pull_i,
  input wire logic clk_stop_i,
  // Device pin drive
  input wire logic reset_pin_n_o,
  input wire logic reset_pin_n_oe_o,
  // Levels seen by the device
  output logic pin_level_o,
  output logic mon_clock_o
);
  logic [1:0] div_r = 2'h0;

  // Pull-up wins only while nobody pulls low
  assign pin_level_o = !((reset_pin_n_oe_o && !reset_pin_n_o) || ext_pull_i);

  // Monitored clock freezes on command, so the detector has something to catch
  always_ff @(posedge sys_clk_i) begin
    if (!clk_stop_i) begin
      div_r <= div_r + 2'h1;
    end
  end
  assign mon_clock_o = div_r[1];
endmodule

// ### testbench/reset_source_controller_bench.sv
`timescale 1ns/1ps

module reset_source_controller_bench;
  localparam int POR = 40;
  localparam logic [3:0] ORG = reset_source_pkg::ORIGIN_OFS;
  localparam logic [3:0] SUP = reset_source_pkg::SUPPLY_OFS;
  localparam logic [3:0] STB = reset_source_pkg::STROBE_OFS;
  localparam logic [1:0] OK = reset_source_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = reset_source_pkg::RESP_SLVERR;
  logic sys_clk_i, rst_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, reset_pin_n_i, reset_pin_n_o, reset_pin_n_oe_o;
  logic supply_ok_i, system_clock_i, cmp_below_i, rtc_alarm_i, rtc_osc_fail_i, flash_illegal_i, flash_wr_req_i;
  logic core_reset_o, flash_wr_allow_o, port_pullup_o, osc_internal_o, wdog_enable_o, ext_pull, clk_stop;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] port_latch_o;
  logic [15:0] pc_reset_o;
  int miscompares = 0;
  int check_count = 0;
  int n;
  // Write keeps supply selection set, so only the source under test can fire
  logic [7:0] src_wd [7] = '{8'h02, 8'h06, 8'h22, 8'h02, 8'h82, 8'h82, 8'h12};
  logic [7:0] src_fl [7] = '{8'h01, 8'h04, 8'h20, 8'h40, 8'h80, 8'h80, 8'h10};

  reset_source_controller #(.POR_CYC(POR), .WDOG_LIMIT(4)) u_reset_source_controller (.sys_clk_i, .rst_i,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reset_pin_n_i, .reset_pin_n_o, .reset_pin_n_oe_o, .supply_ok_i,
    .system_clock_i, .cmp_below_i, .rtc_alarm_i, .rtc_osc_fail_i, .flash_illegal_i, .flash_wr_req_i,
    .core_reset_o, .flash_wr_allow_o, .port_latch_o, .port_pullup_o, .pc_reset_o, .osc_internal_o, .wdog_enable_o);

  analog_partner u_analog_partner (.sys_clk_i, .ext_pull_i(ext_pull), .clk_stop_i(clk_stop), .reset_pin_n_o,
    .reset_pin_n_oe_o, .pin_level_o(reset_pin_n_i), .mon_clock_o(system_clock_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge sys_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      k++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && k < 50);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] ed, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge sys_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      k++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 50);
    s_axi_rready <= 1'b0;
    chk("rresp", 32'(er), 32'(s_axi_rresp));
    if (er == OK) chk("rdata", 32'(ed), s_axi_rdata);
  endtask

  task automatic wait_core(input logic v, input int lim);
    n = 0;
    while (core_reset_o !== v && n < lim) begin
      @(posedge sys_clk_i);
      n++;
    end
    chk("core_reset", 32'(v), 32'(core_reset_o));
  endtask

  task automatic hit(input logic oe);
    wait_core(1'b1, 300);
    @(posedge sys_clk_i);
    chk("pin_drive", 32'(oe), 32'(reset_pin_n_oe_o));
    chk("pin_out", 32'h0, 32'(reset_pin_n_o));
    chk("latch", 32'hFF, 32'(port_latch_o));
    chk("pullup", 32'h1, 32'(port_pullup_o));
  endtask

  // Kick after release and the origin read; the shortened watchdog bites within tens of cycles
  task automatic done(input logic [7:0] fl);
    wait_core(1'b0, 400);
    chk("wdog_en", 32'h1, 32'(wdog_enable_o));
    chk("osc_int", 32'h0, 32'(osc_internal_o));
    chk("pc", 32'h0, 32'(pc_reset_o));
    rd(ORG, fl, OK);
    wr(STB, 8'h01, OK);
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    miscompares++;
    summarize();
  end

  initial begin
    rst_i = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {supply_ok_i, cmp_below_i, rtc_alarm_i, rtc_osc_fail_i, flash_illegal_i, flash_wr_req_i} = '0;
    {ext_pull, clk_stop} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge sys_clk_i);
    chk("core_reset", 32'h1, 32'(core_reset_o));
    chk("latch", 32'hFF, 32'(port_latch_o));
    rst_i <= 1'b0;
    repeat (30) @(posedge sys_clk_i);
    chk("core_reset", 32'h1, 32'(core_reset_o));
    chk("pin_drive", 32'h1, 32'(reset_pin_n_oe_o));
    supply_ok_i <= 1'b1;
    done(8'h02);
    chk("por_delay", 32'h1, 32'(n >= POR));
    rd(SUP, 8'hA0, OK);
    flash_wr_req_i <= 1'b1;
    @(posedge sys_clk_i);
    chk("flash_allow", 32'h1, 32'(flash_wr_allow_o));
    rd(4'hC, 8'h00, ERR);
    wr(4'hC, 8'h55, ERR);
    for (int i = 0; i < 7; i++) begin
      wr(ORG, src_wd[i], OK);
      case (i)
        0: ext_pull <= 1'b1;
        1: clk_stop <= 1'b1;
        2: cmp_below_i <= 1'b1;
        3: flash_illegal_i <= 1'b1;
        4: rtc_alarm_i <= 1'b1;
        5: rtc_osc_fail_i <= 1'b1;
        default: ;
      endcase
      hit(1'b0);
      {ext_pull, clk_stop, cmp_below_i, flash_illegal_i, rtc_alarm_i, rtc_osc_fail_i} <= '0;
      done(src_fl[i]);
    end
    repeat (8) begin
      repeat (20) @(posedge sys_clk_i);
      wr(STB, 8'h01, OK);
    end
    chk("serviced", 32'h0, 32'(core_reset_o));
    hit(1'b0);
    done(8'h08);
    supply_ok_i <= 1'b0;
    hit(1'b1);
    supply_ok_i <= 1'b1;
    done(8'h02);
    chk("fast_release", 32'h1, 32'(n < POR));
    wr(SUP, 8'h00, OK);
    wr(ORG, 8'h10, OK);
    hit(1'b0);
    done(8'h10);
    rd(SUP, 8'h20, OK);
    chk("flash_allow", 32'h0, 32'(flash_wr_allow_o));
    supply_ok_i <= 1'b0;
    repeat (20) @(posedge sys_clk_i);
    chk("core_reset", 32'h0, 32'(core_reset_o));
    supply_ok_i <= 1'b1;
    summarize();
  end
endmodule
